// >>> hw/mrx_exec.sv
// Executor for memory and register reference instructions of a 4-bit core.
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - Flip-row load copies pointed nibble to accumulator, then XORs row with operand.
// - Direct load reads RAM at operand row and digit; pointer untouched.
// - Table read writes ROM high nibble to RAM, low to accumulator, three cycles.
// - Table address uses program counter after the instruction, so next block if it ends a block.
// - Latch table read loads the whole ROM byte into the output latch.
// - Clear-bit opcodes 4C 45 42 43 zero bits zero to three.
// - Set-bit opcodes 4D 47 46 4B set bits zero to three.
// - Store-immediate writes nibble to pointed RAM, then increments digit.
// - Swap exchanges accumulator and RAM, XORs row, digit unchanged.
// - Direct swap, prefix 23 then 1rrrdddd, two cycles, pointer untouched.
// - Swap-decrement skips next instruction when digit wraps zero to fifteen.
// - Swap-increment skips next instruction when digit wraps fifteen to zero.
// - Opcode 50 copies accumulator into digit.
// - Opcode 4E copies digit into accumulator.
// - Pointer load immediate; following pointer loads are suppressed.
// - Pointer loads come in one and two byte forms.
// - Enable load immediate writes low four enable bits.
// - Opcode 12 swaps accumulator and row, zero filling high accumulator bits.
module mrx_exec
  import mrx_pkg::*;
#(
  parameter int ROW_W = 3,
  parameter int PC_W = 11
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] instr,
  output logic [PC_W-1:0] pc,
  output logic [ROW_W+3:0] ram_addr,
  input wire logic [3:0] ram_rdata,
  output logic [3:0] ram_wdata,
  output logic ram_we,
  output logic [PC_W-1:0] rom_addr,
  input wire logic [7:0] rom_data,
  output logic [3:0] acc,
  output logic [ROW_W-1:0] row_pointer,
  output logic [3:0] digit_pointer,
  output logic [7:0] latch_q,
  output logic [7:0] enable_reg
);
  initial begin
    if (ROW_W < 2 || ROW_W > 4 || PC_W < 11) begin
      $error("mrx_exec: unsupported ROW_W or PC_W");
    end
  end

  mrx_state_t state;
  logic [7:0] first;
  logic skip;
  logic chain;
  logic tbl_latch;
  logic [3:0] mem;
  logic [ROW_W+3:0] live_addr;

  // Opcode map as this executor decodes it, one byte per cycle.
  // Plain bytes execute in the fetch cycle itself.
  // The prefix byte opens a second cycle that reads the byte after it.
  // The direct forms (swap and load) also take a second operand cycle.
  // The table reads add a third cycle in which the ROM answers.
  // A skip or a chained pointer load spends one cycle per byte of the real
  // instruction, so the program counter always advances by the byte count.
  //
  // Hazard: the data RAM writes one edge after the executing cycle.
  // An instruction that touches the same nibble straight after a write
  // would read the old value from the array, so the pending write data
  // are forwarded instead. Without this, a bit operation straight after
  // another on the same nibble would lose the update made just before it.
  //
  // Limitation: the direct forms read the RAM through the same port as
  // the pointed forms; the memory beside the core must return the nibble
  // of the operand address during the operand cycle.
  //
  // Trade-off: the pointer and the accumulator update in the same clock
  // process as the sequencer, which keeps every output a plain flip-flop
  // at the cost of one large case statement.

  assign live_addr = (state == MRX_OPERAND) ? (ROW_W+4)'(instr[6:0]) :
                     {row_pointer, digit_pointer};

  // Forward a write still in flight so that a read of the same nibble sees it.
  assign mem = (ram_we && ram_addr == live_addr) ? ram_wdata : ram_rdata;

  function automatic logic [3:0] bit_mask(input logic [7:0] op);
    unique case (op)
      OP_CLR_B0, OP_SET_B0: bit_mask = 4'h1;
      OP_CLR_B1, OP_SET_B1: bit_mask = 4'h2;
      OP_CLR_B2, OP_SET_B2: bit_mask = 4'h4;
      default: bit_mask = 4'h8;
    endcase
  endfunction

  function automatic logic is_lbi1(input logic [7:0] op);
    is_lbi1 = (op[7:6] == 2'b00) && (op[3:0] >= 4'h8);
  endfunction

  // Instruction sequencer; the pointer and data path update in step with it.
  always_ff @(posedge mclk) begin
    ram_we <= 1'b0;
    // The write address travels with the write strobe one edge later.
    ram_addr <= live_addr;
    if (rst) begin
      state <= MRX_FETCH;
      pc <= '0;
      first <= 8'h00;
      skip <= 1'b0;
      chain <= 1'b0;
      tbl_latch <= 1'b0;
      acc <= 4'h0;
      row_pointer <= '0;
      digit_pointer <= 4'h0;
      latch_q <= 8'h00;
      enable_reg <= 8'h00;
      ram_addr <= '0;
      ram_wdata <= 4'h0;
      rom_addr <= '0;
    end else begin
      unique case (state)
        MRX_FETCH: begin
          first <= instr;
          pc <= pc + 1'b1;
          // suppress chained loads; a prefix is judged on its second byte.
          if (chain && is_lbi1(instr)) begin
            chain <= 1'b1;
          end else if (skip) begin
            skip <= 1'b0;
            chain <= 1'b0;
            if (instr == OP_PREFIX || instr == OP_SWAP_DIRECT || instr == OP_LOAD_DIRECT) begin
              state <= MRX_SKIP2;
            end
          end else begin
            chain <= chain && (instr == OP_PREFIX);
            if (instr == OP_PREFIX) begin
              state <= MRX_PREFIX;
            end else if (instr == OP_SWAP_DIRECT || instr == OP_LOAD_DIRECT) begin
              state <= MRX_OPERAND;
            end else if (is_lbi1(instr)) begin
              row_pointer <= ROW_W'(instr[5:4]);
              digit_pointer <= instr[3:0] + 4'h1;
              chain <= 1'b1;
            end else if (instr == OP_ACC_TO_DIGIT) begin
              digit_pointer <= acc;
            end else if (instr == OP_DIGIT_TO_ACC) begin
              acc <= digit_pointer;
            end else if (instr == OP_SWAP_ROW) begin
              acc <= 4'(row_pointer);
              row_pointer <= ROW_W'(acc);
            end else if (instr == OP_CLR_B0 || instr == OP_CLR_B1 ||
                         instr == OP_CLR_B2 || instr == OP_CLR_B3) begin
              ram_wdata <= mem & ~bit_mask(instr);
              ram_we <= 1'b1;
            end else if (instr == OP_SET_B0 || instr == OP_SET_B1 ||
                         instr == OP_SET_B2 || instr == OP_SET_B3) begin
              ram_wdata <= mem | bit_mask(instr);
              ram_we <= 1'b1;
            end else if (instr[7:4] == HI_STORE_INC) begin
              ram_wdata <= instr[3:0];
              ram_we <= 1'b1;
              digit_pointer <= digit_pointer + 4'h1;
            end else if (instr[7:6] == 2'b00 && instr[3:0] == LO_LOAD) begin
              acc <= mem;
              row_pointer <= row_pointer ^ ROW_W'(instr[5:4]);
            end else if (instr[7:6] == 2'b00 && instr[3:0] == LO_SWAP) begin
              acc <= mem;
              ram_wdata <= acc;
              ram_we <= 1'b1;
              row_pointer <= row_pointer ^ ROW_W'(instr[5:4]);
            end else if (instr[7:6] == 2'b00 && instr[3:0] == LO_SWAP_DEC) begin
              acc <= mem;
              ram_wdata <= acc;
              ram_we <= 1'b1;
              row_pointer <= row_pointer ^ ROW_W'(instr[5:4]);
              digit_pointer <= digit_pointer - 4'h1;
              skip <= (digit_pointer == 4'h0);
            end else if (instr[7:6] == 2'b00 && instr[3:0] == LO_SWAP_INC) begin
              acc <= mem;
              ram_wdata <= acc;
              ram_we <= 1'b1;
              row_pointer <= row_pointer ^ ROW_W'(instr[5:4]);
              digit_pointer <= digit_pointer + 4'h1;
              skip <= (digit_pointer == 4'hF);
            end
          end
        end
        MRX_PREFIX: begin
          pc <= pc + 1'b1;
          state <= MRX_FETCH;
          chain <= 1'b0;
          if (instr == OP_TABLE_ACC || instr == OP_TABLE_LATCH) begin
            // address after the instruction, both variants.
            rom_addr <= {pc[PC_W-1:8] + (pc[7:0] == 8'hFF ? 1'b1 : 1'b0), acc, mem};
            tbl_latch <= (instr == OP_TABLE_LATCH);
            state <= MRX_TABLE;
          end else if (instr[7:4] == HI_IRQ_LOAD) begin
            enable_reg[3:0] <= instr[3:0];
          end else if (instr[7] == 1'b1) begin
            // two byte form; a chained copy changes nothing.
            if (!chain) begin
              row_pointer <= ROW_W'(instr[6:4]);
              digit_pointer <= instr[3:0];
            end
            chain <= 1'b1;
          end
        end
        MRX_TABLE: begin
          state <= MRX_FETCH;
          if (tbl_latch) begin
            latch_q <= rom_data;
          end else begin
            ram_wdata <= rom_data[7:4];
            ram_we <= 1'b1;
            acc <= rom_data[3:0];
          end
        end
        MRX_OPERAND: begin
          pc <= pc + 1'b1;
          state <= MRX_FETCH;
          if (first == OP_SWAP_DIRECT) begin
            acc <= mem;
            ram_wdata <= acc;
            ram_we <= 1'b1;
          end else begin
            acc <= mem;
          end
        end
        default: begin
          pc <= pc + 1'b1;
          state <= MRX_FETCH;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// >>> hw/mrx_pkg.sv
// Package for the memory and register reference instruction executor.
package mrx_pkg;
  localparam logic [7:0] OP_PREFIX = 8'h33;
  localparam logic [7:0] OP_TABLE_ACC = 8'h19;
  localparam logic [7:0] OP_TABLE_LATCH = 8'hBF;
  localparam logic [7:0] OP_SWAP_DIRECT = 8'h23;
  localparam logic [7:0] OP_LOAD_DIRECT = 8'h24;
  localparam logic [7:0] OP_ACC_TO_DIGIT = 8'h50;
  localparam logic [7:0] OP_DIGIT_TO_ACC = 8'h4E;
  localparam logic [7:0] OP_SWAP_ROW = 8'h12;
  localparam logic [7:0] OP_CLR_B0 = 8'h4C;
  localparam logic [7:0] OP_CLR_B1 = 8'h45;
  localparam logic [7:0] OP_CLR_B2 = 8'h42;
  localparam logic [7:0] OP_CLR_B3 = 8'h43;
  localparam logic [7:0] OP_SET_B0 = 8'h4D;
  localparam logic [7:0] OP_SET_B1 = 8'h47;
  localparam logic [7:0] OP_SET_B2 = 8'h46;
  localparam logic [7:0] OP_SET_B3 = 8'h4B;
  localparam logic [3:0] HI_LOAD = 4'h0;
  localparam logic [3:0] HI_SWAP = 4'h0;
  localparam logic [3:0] HI_STORE_INC = 4'h7;
  localparam logic [3:0] HI_IRQ_LOAD = 4'h6;
  localparam logic [3:0] LO_LOAD = 4'h5;
  localparam logic [3:0] LO_SWAP = 4'h6;
  localparam logic [3:0] LO_SWAP_DEC = 4'h7;
  localparam logic [3:0] LO_SWAP_INC = 4'h4;
  localparam logic [7:0] LBI2_LO = 8'h80;
  localparam logic [3:0] ROW_BITS = 4'h3;
  localparam logic [7:0] TBL_ADDR_BITS = 8'h0B;
  typedef enum logic [2:0] {
    MRX_FETCH = 3'b000,
    MRX_PREFIX = 3'b001,
    MRX_OPERAND = 3'b010,
    MRX_TABLE = 3'b011,
    MRX_SKIP2 = 3'b100
  } mrx_state_t;
  typedef struct packed {
    logic [2:0] row;
    logic [3:0] digit;
  } mrx_ptr_t;
endpackage

// >>> tb/mrx_mem_model.sv
// Program ROM and data RAM model standing behind the executor.
`timescale 1ns/10ps
`default_nettype none
module mrx_mem_model
  import mrx_pkg::*;
#(
  parameter int ROW_W = 3,
  parameter int PC_W = 11
) (
  input wire logic mclk,
  input wire logic [PC_W-1:0] pc,
  output logic [7:0] instr,
  input wire logic [ROW_W+3:0] ram_addr,
  input wire logic [ROW_W-1:0] row_pointer,
  input wire logic [3:0] digit_pointer,
  output logic [3:0] ram_rdata,
  input wire logic [3:0] ram_wdata,
  input wire logic ram_we,
  input wire logic [PC_W-1:0] rom_addr,
  output logic [7:0] rom_data
);
  logic [7:0] rom [2**PC_W];
  logic [3:0] ram [2**(ROW_W+4)];
  // Fetch and table reads share one image, as on the real part.
  assign instr = rom[pc];
  assign rom_data = rom[rom_addr];
  assign ram_rdata = ram[{row_pointer, digit_pointer}];
  // Plain always block, because the bench also seeds cells between runs.
  always @(posedge mclk) begin
    if (ram_we) begin
      ram[ram_addr] <= ram_wdata;
    end
  end
endmodule
`default_nettype wire

// >>> tb/mrx_exec_sva.sv
// Port checker for the instruction executor.
`timescale 1ns/10ps
`default_nettype none
module mrx_exec_sva
  import mrx_pkg::*;
#(
  parameter int ROW_W = 3,
  parameter int PC_W = 11
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] instr,
  input wire logic [PC_W-1:0] pc,
  input wire logic [ROW_W+3:0] ram_addr,
  input wire logic [3:0] ram_rdata,
  input wire logic [3:0] ram_wdata,
  input wire logic ram_we,
  input wire logic [3:0] acc,
  input wire logic [ROW_W-1:0] row_pointer,
  input wire logic [3:0] digit_pointer
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (rst);
  // Nibble the executor really sees: a write in flight to the pointed cell wins.
  logic [3:0] old_nib;
  assign old_nib = (ram_we && ram_addr == {row_pointer, digit_pointer}) ? ram_wdata : ram_rdata;
  // An opcode byte that is not the second byte of a prefixed pair.
  sequence op(logic [7:0] c);
    instr == c && $past(instr) != OP_PREFIX;
  endsequence
  chk_pc_steps: assert property (1'b1 |=> pc == $past(pc) || pc == PC_W'($past(pc) + 1'b1))
    else $error("pc jump");
  chk_set_bit: assert property (op(OP_SET_B0) ##1 ram_we |-> ram_wdata[0]
    && ram_wdata[3:1] == $past(old_nib[3:1])) else $error("set bit");
  chk_clear_bit: assert property (op(OP_CLR_B1) ##1 ram_we |-> !ram_wdata[1]
    && ram_wdata[0] == $past(old_nib[0])) else $error("clear bit");
  chk_ram_addr_form: assert property (op(OP_SET_B3) ##1 ram_we |->
    ram_addr == {$past(row_pointer), $past(digit_pointer)}) else $error("ram addr");
  chk_store_inc: assert property ((instr[7:4] == HI_STORE_INC && $past(instr) != OP_PREFIX)
    ##1 ram_we |-> ram_wdata == $past(instr[3:0]) && $stable(row_pointer)
    && digit_pointer == 4'($past(digit_pointer) + 1)) else $error("store inc");
  chk_digit_to_acc: assert property (op(OP_DIGIT_TO_ACC) ##1 $changed(acc) |->
    acc == $past(digit_pointer) && $stable(digit_pointer)) else $error("digit to acc");
  chk_acc_to_digit: assert property (op(OP_ACC_TO_DIGIT) ##1 $changed(digit_pointer) |->
    digit_pointer == $past(acc) && $stable(acc) && $stable(row_pointer)) else $error("acc to digit");
  chk_swap_row: assert property (op(OP_SWAP_ROW) ##1 ($changed(acc) || $changed(row_pointer))
    |-> acc == 4'($past(row_pointer)) && row_pointer == $past(acc[ROW_W-1:0]))
    else $error("swap row");
  cover property (op(OP_SET_B0) ##1 ram_we);
  cover property (instr == OP_PREFIX ##1 instr == OP_TABLE_ACC);
  cover property (op(OP_SWAP_ROW) ##1 $changed(acc));
endmodule
bind mrx_exec mrx_exec_sva #(.ROW_W(ROW_W), .PC_W(PC_W)) u_sva (.mclk(mclk), .rst(rst),
  .instr(instr), .pc(pc), .ram_addr(ram_addr), .ram_rdata(ram_rdata), .ram_wdata(ram_wdata),
  .ram_we(ram_we), .acc(acc), .row_pointer(row_pointer), .digit_pointer(digit_pointer));
`default_nettype wire

// >>> tb/testbench.sv
// Self-checking bench running short programs through the executor.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import mrx_pkg::*;
  logic mclk, rst, ram_we;
  logic [7:0] instr, rom_data, latch_q, enable_reg;
  logic [10:0] pc, rom_addr;
  logic [6:0] ram_addr;
  logic [3:0] ram_rdata, ram_wdata, acc, digit_pointer;
  logic [2:0] row_pointer;
  int failures = 0;
  int n_compared = 0;
  int cycles = 0;
  mrx_exec #(.ROW_W(3), .PC_W(11)) DUT (.mclk(mclk), .rst(rst), .instr(instr), .pc(pc),
    .ram_addr(ram_addr), .ram_rdata(ram_rdata), .ram_wdata(ram_wdata), .ram_we(ram_we),
    .rom_addr(rom_addr), .rom_data(rom_data), .acc(acc), .row_pointer(row_pointer),
    .digit_pointer(digit_pointer), .latch_q(latch_q), .enable_reg(enable_reg));
  mrx_mem_model u_mem (.mclk(mclk), .pc(pc), .instr(instr), .ram_addr(ram_addr),
    .row_pointer(row_pointer), .digit_pointer(digit_pointer), .ram_rdata(ram_rdata),
    .ram_wdata(ram_wdata), .ram_we(ram_we), .rom_addr(rom_addr), .rom_data(rom_data));
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  // A hung program still reaches the verdict.
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 1000) begin
      failures++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Reset, load the image, release, and run until the last byte is consumed.
  // Seeding waits two edges so a write still in flight cannot undo it.
  task automatic run(input logic [7:0] p[$], input int pa, input logic [3:0] pv);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    for (int i = 0; i < 2048; i++) begin
      u_mem.rom[i] = 8'(i) ^ 8'h5A;
      u_mem.ram[7'(i)] = 4'h0;
    end
    foreach (p[i]) begin
      u_mem.rom[i] = p[i];
    end
    u_mem.ram[pa] = pv;
    repeat (14) @(posedge mclk);
    rst <= 1'b0;
    for (int k = 0; k < 60 && pc != 11'(p.size()); k++) begin
      @(negedge mclk);
    end
  endtask
  task automatic t_chain();
    run('{8'h33, 8'hA5, 8'h33, 8'hB3, 8'h4E}, 0, 4'h0);
    chk({acc, digit_pointer, 1'b0, row_pointer, u_mem.ram[0]}, 16'h5520);
    $display("chain test done");
  endtask
  // Table byte at 0x0C splits high nibble to RAM and low to the accumulator.
  task automatic t_table();
    run('{8'h33, 8'h9F, 8'h7C, 8'h4E, 8'h33, 8'h9F, 8'h33, 8'h19, 8'h50}, 0, 4'h0);
    chk({acc, digit_pointer, 1'b0, row_pointer, u_mem.ram[7'h1F]}, 16'h6615);
    $display("table test done");
  endtask
  // The trailing copy must be skipped when the digit wraps.
  task automatic t_bits();
    run('{8'h33, 8'h80, 8'h4D, 8'h4B, 8'h45, 8'h33, 8'h8F, 8'h04, 8'h4E}, 15, 4'h3);
    chk({acc, digit_pointer, 1'b0, row_pointer, u_mem.ram[0]}, 16'h3009);
    chk({12'h000, u_mem.ram[7'h0F]}, 16'h0000);
    $display("bits test done");
  endtask
  // Enable load, then a latch table read at 0x0A of the bench image.
  task automatic t_latch();
    run('{8'h33, 8'h63, 8'h33, 8'hBF, 8'h4E}, 0, 4'hA);
    chk({latch_q, enable_reg}, 16'h5003);
    chk({5'h00, rom_addr}, 16'h000A);
    $display("latch test done");
  endtask
  task automatic t_swap_row();
    run('{8'h33, 8'hD0, 8'h12, 8'h50}, 0, 4'h0);
    chk({acc, digit_pointer, 1'b0, row_pointer, u_mem.ram[0]}, 16'h5500);
    $display("swap row test done");
  endtask
  task automatic tally_and_finish();
    $display("compared %0d mismatched %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    rst = 1'b1;
    t_chain();
    t_table();
    t_bits();
    t_swap_row();
    t_latch();
    tally_and_finish();
  end
endmodule
`default_nettype wire
